/* File: hw/sdm_core.v */
// command-side core of a four-bank synchronous dram module
// assumes a controller that performs the power-up sequence and refresh itself
`timescale 1ns/1ps
`include "sdm_map.vh"

module sdm_core #(
   parameter RW = 13,
   parameter DW = 64
) (
   input  wire          clk,               // system clock
   input  wire          rst_b,             // synchronous reset, active low (model only)
   input  wire          cs_b,              // chip select, active low
   input  wire          ras_b,             // row strobe, active low
   input  wire          cas_b,             // column strobe, active low
   input  wire          we_b,              // write strobe, active low
   input  wire          bank_select_low,   // bank bit 0
   input  wire          bank_select_high,  // bank bit 1
   input  wire [RW-1:0] row_column_address_lines, // address lines
   input  wire [DW-1:0] wdata,             // write data bus in
   output reg  [DW-1:0] rdata_q,           // read data bus out
   output reg           rdata_oe_q,        // read data drive enable
   output reg           wr_en_q,           // internal array write strobe
   output reg  [1:0]    acc_bank_q,        // bank of current access
   output reg  [RW-1:0] acc_row_q,         // row of current access
   output reg  [9:0]    acc_col_q,         // column of current access
   output reg  [DW-1:0] wr_data_q,         // data to array
   input  wire [DW-1:0] arr_rdata,         // data from array for acc_col_q
   output wire [3:0]    bank_open,         // open-row state per bank
   output wire [`SDM_MR_WIDTH-1:0] operating_mode_setting // mode register view
);

   localparam PRE_CYC_RAW = (`SDM_TRP_NS + `SDM_CLK_NS - 1) / `SDM_CLK_NS;
   localparam PRE_CYC     = (PRE_CYC_RAW < 1) ? 1 : PRE_CYC_RAW;

   // burst states
   localparam ST_IDLE = 2'h0;
   localparam ST_RD   = 2'h1;
   localparam ST_WR   = 2'h2;

   // =========================================================
   // command decode
   // =========================================================
   wire [2:0] cmd = cs_b ? `SDM_CMD_NOP : {ras_b, cas_b, we_b};
   wire [1:0] ba  = {bank_select_high, bank_select_low};
   wire       ap  = row_column_address_lines[`SDM_AP_BIT];

   // =========================================================
   // mode register
   // =========================================================
   reg [`SDM_MR_WIDTH-1:0] mode_q;
   assign operating_mode_setting = mode_q;

   always @(posedge clk)
   begin
      if (!rst_b)
         mode_q <= {`SDM_MR_WIDTH{1'b0}};
      else if (cmd == `SDM_CMD_MRS)
         mode_q <= row_column_address_lines[`SDM_MR_WIDTH-1:0];
   end

   wire [2:0] bl_code = mode_q[`SDM_MR_BL_MSB:`SDM_MR_BL_LSB];
   wire       bt_ilv  = mode_q[`SDM_MR_BT_BIT];
   wire [2:0] cl_code = mode_q[`SDM_MR_CL_MSB:`SDM_MR_CL_LSB];
   wire       wb_one  = mode_q[`SDM_MR_WB_BIT];

   // full page is sequential only; interleave is ignored there
   wire       ilv_eff = bt_ilv && (bl_code != `SDM_BL_PAGE);

   function [10:0] beats;
      input [2:0] c;
      begin
         case (c)
            `SDM_BL_1    : beats = 11'h001;
            `SDM_BL_2    : beats = 11'h002;
            `SDM_BL_4    : beats = 11'h004;
            `SDM_BL_8    : beats = 11'h008;
            `SDM_BL_PAGE : beats = 11'h7ff;  // runs until terminated
            default      : beats = 11'h001;
         endcase
      end
   endfunction

   // =========================================================
   // burst engine
   // =========================================================
   reg [1:0]    st_q;
   reg [10:0]   left_q;
   reg [9:0]    step_q;
   reg [9:0]    start_q;
   reg [1:0]    bank_q;
   reg [2:0]    len_q;
   reg          ap_q;
   wire [9:0]   col;
   wire [9:0]   start_now = row_column_address_lines[9:0];
   wire         is_rw     = (cmd == `SDM_CMD_RD) || (cmd == `SDM_CMD_WR);
   wire         burst_end = (st_q != ST_IDLE) && (left_q == 11'h001) && !is_rw
                            && (cmd != `SDM_CMD_BST);
   wire         bst       = (st_q != ST_IDLE) && (cmd == `SDM_CMD_BST);

   sdm_col_gen #(.CW(10)) u_col (
      .start_col  (is_rw ? start_now : start_q),
      .len_code   (is_rw ? ((cmd == `SDM_CMD_WR && wb_one) ? `SDM_BL_1 : bl_code) : len_q),
      .interleave (ilv_eff),
      .step       (is_rw ? 10'h000 : step_q),
      .col        (col)
   );

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         st_q    <= ST_IDLE;
         left_q  <= 11'h000;
         step_q  <= 10'h000;
         start_q <= 10'h000;
         bank_q  <= 2'h0;
         len_q   <= `SDM_BL_1;
         ap_q    <= 1'b0;
      end
      else if (is_rw)
      begin
         // a new column command interrupts any burst, every cycle allowed
         st_q    <= (cmd == `SDM_CMD_RD) ? ST_RD : ST_WR;
         start_q <= start_now;
         bank_q  <= ba;
         ap_q    <= ap;
         if (cmd == `SDM_CMD_WR && wb_one)
         begin
            len_q  <= `SDM_BL_1;
            left_q <= 11'h001;
         end
         else
         begin
            len_q  <= bl_code;
            left_q <= beats(bl_code);
         end
         step_q  <= 10'h001;
      end
      else if (bst || burst_end)
      begin
         st_q   <= ST_IDLE;
         left_q <= 11'h000;
      end
      else if (st_q != ST_IDLE)
      begin
         step_q <= step_q + 10'h001;
         if (len_q != `SDM_BL_PAGE)
            left_q <= left_q - 11'h001;
      end
   end

   wire        beat_now = is_rw || ((st_q != ST_IDLE) && !bst && !burst_end);
   wire        beat_wr  = is_rw ? (cmd == `SDM_CMD_WR) : (st_q == ST_WR);
   wire [1:0]  beat_bnk = is_rw ? ba : bank_q;

   // =========================================================
   // banks
   // =========================================================
   wire [RW-1:0] rows [0:3];
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_bank
         sdm_bank #(.RW(RW), .PRE_CYC(PRE_CYC)) u_bank (
            .clk    (clk),
            .rst_b  (rst_b),
            .act    ((cmd == `SDM_CMD_ACT) && (ba == gi)),
            .row_in (row_column_address_lines),
            .pre    ((cmd == `SDM_CMD_PRE) && (ap || ba == gi)),
            .ap_arm (ap_q && (burst_end || bst) && (bank_q == gi)),
            .open_q (bank_open[gi]),
            .row_q  (rows[gi])
         );
      end
   endgenerate

   // =========================================================
   // array access and read latency pipe
   // =========================================================
   reg [DW-1:0] lat_d_q;
   reg [1:0]    lat_v_q;

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         wr_en_q    <= 1'b0;
         acc_bank_q <= 2'h0;
         acc_row_q  <= {RW{1'b0}};
         acc_col_q  <= 10'h000;
         wr_data_q  <= {DW{1'b0}};
         lat_v_q    <= 2'h0;
         lat_d_q    <= {DW{1'b0}};
         rdata_q    <= {DW{1'b0}};
         rdata_oe_q <= 1'b0;
      end
      else
      begin
         acc_bank_q <= beat_bnk;
         acc_row_q  <= rows[beat_bnk];
         acc_col_q  <= col;
         wr_en_q    <= beat_now && beat_wr;
         wr_data_q  <= wdata;
         // valid bit 0 rises with the access address; array data follows
         // combinationally, so latency two drives it out on the next edge
         lat_v_q    <= {lat_v_q[0], beat_now && !beat_wr};
         lat_d_q    <= arr_rdata;
         if (cl_code == `SDM_CL_3)
         begin
            rdata_q    <= lat_d_q;
            rdata_oe_q <= lat_v_q[1];
         end
         else
         begin
            rdata_q    <= arr_rdata;
            rdata_oe_q <= lat_v_q[0];
         end
      end
   end

endmodule // sdm_core

/* File: hw/sdm_map.vh */
// constants for the sdram module command side: command codes, mode fields, timing
// assumes inclusion by every design file of the sdm block; definitions only
// What this block does
// - every input is captured on the rising clock edge; controller meets that edge
// - access starts with activate; bank from two bank bits, row from address lines
// - read or write takes address bits 0 to 9 as starting column
// - burst lengths 1, 2, 4, 8 or full page; burst terminate cuts short
// - auto precharge starts a self-timed row close after the burst ends
// - new column address accepted every cycle; other banks precharge meanwhile
// - mode register is unknown after power up; load before operational commands (this model clears it to 0 on reset)
// - mode settings stay unchanged until the next load mode register command
// - mode layout: length 2:0, order 3, latency 6:4, op mode 8:7, write 9
// - lengths 1 to 8 offer both orders; full page only sequential
// - burst wraps inside an aligned block the size of the burst length
// - full page burst wraps at the last column within the same row
// - line 10 is auto precharge on read or write, all banks on precharge
// - activate: select, row strobe low; read: select and column strobe low only
// - read latency of two or three clocks from read to first data
`ifndef SDM_MAP_VH
`define SDM_MAP_VH

// command codes {row strobe, column strobe, write strobe}, all active low
`define SDM_CMD_MRS     3'h0
`define SDM_CMD_REF     3'h1
`define SDM_CMD_PRE     3'h2
`define SDM_CMD_ACT     3'h3
`define SDM_CMD_WR      3'h4
`define SDM_CMD_RD      3'h5
`define SDM_CMD_BST     3'h6
`define SDM_CMD_NOP     3'h7

// mode register field positions
`define SDM_MR_BL_LSB   0
`define SDM_MR_BL_MSB   2
`define SDM_MR_BT_BIT   3
`define SDM_MR_CL_LSB   4
`define SDM_MR_CL_MSB   6
`define SDM_MR_WB_BIT   9
`define SDM_MR_WIDTH    13

// burst length encodings
`define SDM_BL_1        3'h0
`define SDM_BL_2        3'h1
`define SDM_BL_4        3'h2
`define SDM_BL_8        3'h3
`define SDM_BL_PAGE     3'h7

// read latency encodings
`define SDM_CL_2        3'h2
`define SDM_CL_3        3'h3

// address line carrying the precharge flag
`define SDM_AP_BIT      10
`define SDM_COL_WIDTH   10

// self-timed precharge duration, in ns, and the clock period
`define SDM_TRP_NS      20
`define SDM_CLK_NS      25

`endif

/* File: hw/sdm_col_gen.v */
// column address generator for one burst: wraps within the burst block or page
// assumes the start column, length code and order bit are held during the burst
`timescale 1ns/1ps
`include "sdm_map.vh"

module sdm_col_gen #(
   parameter CW = `SDM_COL_WIDTH
) (
   input  wire [CW-1:0] start_col,   // column sampled with the command
   input  wire [2:0]    len_code,    // burst length code
   input  wire          interleave,  // burst order, 1 = interleaved
   input  wire [CW-1:0] step,        // beat index inside the burst
   output reg  [CW-1:0] col          // column for this beat
);

   reg [CW-1:0] seq;
   reg [CW-1:0] ilv;

   always @*
   begin
      seq = start_col + step;
      ilv = start_col ^ step;
      col = start_col;
      case (len_code)
         `SDM_BL_1    : col = start_col;
         `SDM_BL_2    : col = {start_col[CW-1:1], seq[0]};
         `SDM_BL_4    : col = {start_col[CW-1:2], (interleave ? ilv[1:0] : seq[1:0])};
         `SDM_BL_8    : col = {start_col[CW-1:3], (interleave ? ilv[2:0] : seq[2:0])};
         `SDM_BL_PAGE : col = seq;
         default      : col = start_col;
      endcase
   end

endmodule // sdm_col_gen

/* File: hw/sdm_bank.v */
// per-bank state: open row and self-timed auto precharge countdown
// assumes commands arrive already decoded and addressed to this bank
`timescale 1ns/1ps
`include "sdm_map.vh"

module sdm_bank #(
   parameter RW      = 13,
   parameter PRE_CYC = 1
) (
   input  wire          clk,        // system clock
   input  wire          rst_b,      // synchronous reset, active low
   input  wire          act,        // activate this bank
   input  wire [RW-1:0] row_in,     // row with activate
   input  wire          pre,        // precharge this bank now
   input  wire          ap_arm,     // auto precharge request at burst end
   output reg           open_q,     // row open
   output reg  [RW-1:0] row_q       // open row
);

   // countdown load value, cut to the counter width on purpose
   localparam [3:0] PRE_LOAD = PRE_CYC;

   reg [3:0] pre_cnt_q;
   reg       closing_q;

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         open_q    <= 1'b0;
         row_q     <= {RW{1'b0}};
         pre_cnt_q <= 4'h0;
         closing_q <= 1'b0;
      end
      else
      begin
         if (act)
         begin
            open_q <= 1'b1;
            row_q  <= row_in;
         end
         else if (pre)
            open_q <= 1'b0;
         // self-timed close, runs while other banks stay in use
         if (ap_arm)
         begin
            closing_q <= 1'b1;
            pre_cnt_q <= PRE_LOAD;
         end
         else if (closing_q)
         begin
            if (pre_cnt_q <= 4'h1)
            begin
               closing_q <= 1'b0;
               // an activate in the same cycle wins over the timed close
               if (!act)
                  open_q <= 1'b0;
            end
            else
               pre_cnt_q <= pre_cnt_q - 4'h1;
         end
      end
   end

endmodule // sdm_bank

/* File: test/sdm_arr_model.sv */
// array partner: answers each access with a pattern made of its location
// assumes the core reads the array combinationally
`timescale 1ns/1ps
//==========
// array model
module sdm_arr_model (
   input  wire [1:0]  bank,  // access bank
   input  wire [12:0] row,   // access row
   input  wire [9:0]  col,   // access column
   output wire [63:0] rdata  // data
);
   // inverted copy shows a wrong bank or row in every field
   assign rdata = {14'h0, ~{bank, row, col}, bank, row, col};
endmodule // sdm_arr_model

/* File: test/sdm_core_monitor.sv */
// checker on the sdm_core ports: mode, bank state, bursts, read latency
// assumes one clock and the synchronous active-low reset
`timescale 1ns/1ps
`include "sdm_map.vh"
//==========
// checker
module sdm_monitor (
   input wire        clk,                      // clock
   input wire        rst_b,                    // reset
   input wire        cs_b,                     // select
   input wire        ras_b,                    // row strobe
   input wire        cas_b,                    // column strobe
   input wire        we_b,                     // write strobe
   input wire        bank_select_low,          // bank 0
   input wire        bank_select_high,         // bank 1
   input wire [12:0] row_column_address_lines, // address
   input wire [63:0] wdata,                    // write data
   input wire        rdata_oe_q,               // read drive
   input wire        wr_en_q,                  // array write
   input wire [1:0]  acc_bank_q,               // bank
   input wire [9:0]  acc_col_q,                // column
   input wire [63:0] wr_data_q,                // array data
   input wire [3:0]  bank_open,                // open rows
   input wire [12:0] operating_mode_setting    // mode
);
   wire [2:0]  cmd = {ras_b, cas_b, we_b};
   wire [1:0]  ba  = {bank_select_high, bank_select_low};
   wire        sel = !cs_b;
   wire        rw  = sel && (cmd == `SDM_CMD_RD || cmd == `SDM_CMD_WR);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   mode_load_a: assert property (sel && cmd == `SDM_CMD_MRS |=>
      operating_mode_setting == $past(row_column_address_lines)) else $error("mode not loaded");
   mode_hold_a: assert property (!(sel && cmd == `SDM_CMD_MRS) |=>
      $stable(operating_mode_setting)) else $error("mode changed");
   act_open_a: assert property (sel && cmd == `SDM_CMD_ACT |=>
      bank_open[$past(ba)]) else $error("row not opened");
   col_take_a: assert property (rw |=> acc_col_q == $past(row_column_address_lines[9:0])
      && acc_bank_q == $past(ba)) else $error("column not taken");
   wr_take_a: assert property (sel && cmd == `SDM_CMD_WR |=>
      wr_en_q && wr_data_q == $past(wdata)) else $error("write data not taken");
   pre_all_a: assert property (sel && cmd == `SDM_CMD_PRE && row_column_address_lines[10]
      |-> ##[1:2] bank_open == 4'h0) else $error("banks not closed");
   read_cl2_a: assert property (sel && cmd == `SDM_CMD_RD
      && operating_mode_setting[6:4] == `SDM_CL_2 |-> ##2 rdata_oe_q) else $error("latency two");
   read_cl3_a: assert property (sel && cmd == `SDM_CMD_RD
      && operating_mode_setting[6:4] == `SDM_CL_3 |-> ##3 rdata_oe_q) else $error("latency three");
   wrap_eight_a: assert property (wr_en_q && $past(wr_en_q) && !$past(rw)
      && operating_mode_setting[2:0] == `SDM_BL_8 |-> acc_col_q[9:3] == $past(acc_col_q[9:3]))
      else $error("burst left its block");
endmodule // sdm_monitor
bind sdm_core sdm_monitor u_sdm_monitor (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .ras_b(ras_b),
   .cas_b(cas_b), .we_b(we_b), .bank_select_low(bank_select_low),
   .bank_select_high(bank_select_high), .row_column_address_lines(row_column_address_lines),
   .wdata(wdata), .rdata_oe_q(rdata_oe_q), .wr_en_q(wr_en_q), .acc_bank_q(acc_bank_q),
   .acc_col_q(acc_col_q), .wr_data_q(wr_data_q), .bank_open(bank_open),
   .operating_mode_setting(operating_mode_setting));

/* File: test/test_sdm_core.sv */
// self-checking bench for sdm_core: start-up, mode, bursts, reads, precharge
// assumes the array model answers combinationally
`timescale 1ns/1ps
`include "sdm_map.vh"
//==========
// bench
module test_sdm_core;
   reg          clk;
   reg          rst_b;
   reg          cs_b;
   reg  [2:0]   c;
   reg  [1:0]   ba;
   reg  [12:0]  a;
   reg  [63:0]  wdata;
   reg  [9:0]   s;
   reg  [12:0]  tm [0:5];
   wire [63:0]  rdata_q;
   wire [63:0]  arr_rdata;
   wire         rdata_oe_q;
   wire         wr_en_q;
   wire [1:0]   acc_bank_q;
   wire [12:0]  acc_row_q;
   wire [9:0]   acc_col_q;
   wire [63:0]  wr_data_q;
   wire [3:0]   bank_open;
   wire [12:0]  mode;
   integer      fail_count;
   integer      n_compared;
   integer      i;
   integer      k;
   integer      n;
   sdm_core u_sdm_core (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .ras_b(c[2]), .cas_b(c[1]),
      .we_b(c[0]), .bank_select_low(ba[0]), .bank_select_high(ba[1]),
      .row_column_address_lines(a), .wdata(wdata), .rdata_q(rdata_q), .rdata_oe_q(rdata_oe_q),
      .wr_en_q(wr_en_q), .acc_bank_q(acc_bank_q), .acc_row_q(acc_row_q),
      .acc_col_q(acc_col_q), .wr_data_q(wr_data_q), .arr_rdata(arr_rdata),
      .bank_open(bank_open), .operating_mode_setting(mode));
   sdm_arr_model u_sdm_arr_model (.bank(acc_bank_q), .row(acc_row_q), .col(acc_col_q),
      .rdata(arr_rdata));
   always #12.5 clk = ~clk;
   task chk(input [63:0] nm, input [63:0] e, input [63:0] g);
   begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
         fail_count = fail_count + 1;
         $display("Error %0s expected %h seen %h", nm, e, g);
      end
   end
   endtask
   task end_sim;
   begin
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   task cmd(input [2:0] cc, input [1:0] b, input [12:0] ad);
   begin
      @(posedge clk);
      #1;
      cs_b = 1'b0;
      c = cc;
      ba = b;
      a = ad;
   end
   endtask
   // banks are closed first so the load always meets the all-idle condition
   task setmode(input [12:0] m);
   begin
      cmd(`SDM_CMD_PRE, 2'h0, 13'h0400);
      cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
      cmd(`SDM_CMD_MRS, 2'h0, m);
      cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
      cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
      chk("mode", 64'(m), 64'(mode));
   end
   endtask
   function [9:0] ecol(input [9:0] st, input [2:0] bl, input il, input [9:0] kk);
      reg [9:0] m;
   begin
      m = (bl == `SDM_BL_PAGE) ? 10'h3ff : ((10'h1 << bl) - 10'h1);
      ecol = (st & ~m) | ((il ? (st ^ kk) : (st + kk)) & m);
   end
   endfunction
   task t_init;
   begin
      chk("mode0", 64'h0, 64'(mode));
      chk("open0", 64'h0, 64'(bank_open));
      repeat (4000) cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
      cmd(`SDM_CMD_PRE, 2'h0, 13'h0400);
      cmd(`SDM_CMD_REF, 2'h0, 13'h0000);
      repeat (4) cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
      cmd(`SDM_CMD_REF, 2'h0, 13'h0000);
      repeat (4) cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
      setmode(13'h0020);
      @(posedge clk);
      #1;
      cs_b = 1'b1;
      c = `SDM_CMD_MRS;
      a = 13'h0fff;
      cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
      cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
      chk("desel", 64'h20, 64'(mode));
      $display("init test done");
   end
   endtask
   task t_read;
   begin
      for (i = 2; i <= 3; i = i + 1)
      begin
         setmode({6'h0, i[2:0], 4'h0});
         cmd(`SDM_CMD_ACT, 2'h3, 13'h1abc);
         cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
         chk("open", 64'h8, 64'(bank_open));
         cmd(`SDM_CMD_RD, 2'h3, 13'h0155);
         cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
         n = 0;
         for (k = 1; k <= 8; k = k + 1)
         begin
            @(posedge clk);
            #1;
            if (rdata_oe_q === 1'b1 && n == 0)
               n = k;
         end
         chk("latency", 64'(i - 1), 64'(n));
      end
      setmode(13'h0020);
      cmd(`SDM_CMD_ACT, 2'h3, 13'h1abc);
      cmd(`SDM_CMD_RD, 2'h3, 13'h02aa);
      repeat (2) cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
      chk("rd_oe", 64'h1, 64'(rdata_oe_q));
      chk("rdata", {14'h0, ~{2'h3, 13'h1abc, 10'h2aa}, 2'h3, 13'h1abc, 10'h2aa}, rdata_q);
      $display("read test done");
   end
   endtask
   task t_burst;
   begin
      for (i = 0; i < 6; i = i + 1)
      begin
         setmode(tm[i]);
         cmd(`SDM_CMD_ACT, 2'h1, 13'h0033);
         s = (i == 4) ? 10'h3fd : 10'h2b5;
         wdata = 64'h0123_4567_89ab_cdef ^ 64'(i);
         cmd(`SDM_CMD_WR, 2'h1, {3'h0, s});
         cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
         chk("wdata", wdata, wr_data_q);
         n = tm[i][9] ? 1 : (1 << tm[i][2:0]);
         for (k = 0; k < 5; k = k + 1)
         begin
            if (k < n)
               chk("col", 64'(ecol(s, tm[i][2:0], tm[i][3], k[9:0])), 64'(acc_col_q));
            else
               chk("beat", 64'h0, 64'(wr_en_q));
            @(posedge clk);
            #1;
         end
         cmd(`SDM_CMD_BST, 2'h0, 13'h0000);
         repeat (2) cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
         chk("stop", 64'h0, 64'(wr_en_q));
      end
      $display("burst test done");
   end
   endtask
   task t_ap;
   begin
      setmode(13'h0022);
      cmd(`SDM_CMD_ACT, 2'h0, 13'h0011);
      cmd(`SDM_CMD_ACT, 2'h2, 13'h0022);
      cmd(`SDM_CMD_WR, 2'h2, 13'h0404);
      cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
      chk("ap_hold", 64'h5, 64'(bank_open));
      k = 0;
      while (bank_open !== 4'h1 && k < 8)
      begin
         cmd(`SDM_CMD_NOP, 2'h0, 13'h0000);
         k = k + 1;
      end
      chk("ap_close", 64'h1, 64'(bank_open));
      $display("precharge test done");
   end
   endtask
   initial
   begin
      repeat (100000) @(posedge clk);
      fail_count = fail_count + 1;
      end_sim;
   end
   initial
   begin
      clk = 1'b0;
      rst_b = 1'b0;
      cs_b = 1'b1;
      c = `SDM_CMD_NOP;
      ba = 2'h0;
      a = 13'h0000;
      wdata = 64'h0;
      s = 10'h0;
      fail_count = 0;
      n_compared = 0;
      tm[0] = 13'h0021;
      tm[1] = 13'h002a;
      tm[2] = 13'h0023;
      tm[3] = 13'h002b;
      tm[4] = 13'h0027;
      tm[5] = 13'h0223;
      repeat (16) @(posedge clk);
      #1;
      rst_b = 1'b1;
      t_init;
      t_read;
      t_burst;
      t_ap;
      end_sim;
   end
endmodule // test_sdm_core
